// >>> pcr_params.svh
// Constants for the clock-run control block: offsets, field positions,
// reset values and edge counts. Included by the package and the top.
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

`define PCR_ADDR_W            12
`define PCR_OFF_CTRL_STATUS   12'h03C
`define PCR_OFF_IRQ_STATUS    12'h050
`define PCR_OFF_IRQ_MASK      12'h054

`define PCR_BIT_PME_STATUS    15
`define PCR_BIT_PME_ENABLE    8
`define PCR_BIT_CLKREQ_SEL    0

`define PCR_CTRL_STATUS_RST   32'h0000_0000
`define PCR_IRQ_RST           3'h0

`define PCR_IRQ_W             3
`define PCR_IRQ_BIT_START     0
`define PCR_IRQ_BIT_CONT      1
`define PCR_IRQ_BIT_PME       2

`define PCR_ASSERT_EDGES      2'h2
`define PCR_DEASSERT_EDGES    2'h2

`endif

// >>> pcr_pkg.sv
// Types shared by the clock-run control files.
// Assumes pcr_params.svh is on the include path.
`include "pcr_params.svh"

package pcr_pkg;

   typedef enum logic [1:0] {
      PCR_IDLE     = 2'b00,
      PCR_DRIVE    = 2'b01,
      PCR_WAIT_LOW = 2'b10
   } pcr_state_type;

   typedef logic [1:0] pcr_count_type;

endpackage : pcr_pkg

// >>> pcr_sync2.sv
// Two-stage synchroniser for one asynchronous level.
// Assumes the input comes from a pin outside the pclk domain.
`timescale 1ns/1ps

module pcr_sync2 #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta_r;
   logic sync_r;
   logic meta_nxt;
   logic sync_nxt;

   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= RESET_VAL;
         sync_r <= RESET_VAL;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_out = sync_r;

endmodule : pcr_sync2

// >>> pcr_rx_clk_sel.sv
// Receive-block clock source select that follows the clock-run line.
// Assumes a synchronised line level; the clock mux itself sits outside.
`timescale 1ns/1ps

module pcr_rx_clk_sel (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic mode_clock_run,
   input  wire logic line_high,
   output logic      use_crystal
);

   logic sel_r;
   logic sel_nxt;

   // Line high means the pci clock is stopped or slowed
   always_comb begin
      sel_nxt = mode_clock_run & line_high;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_r <= 1'b0;
      end else begin
         sel_r <= sel_nxt;
      end
   end

   assign use_crystal = sel_r;

endmodule : pcr_rx_clk_sel

// >>> pcr_top.sv
// Clock-run control/status register, shared wake/clock-run pin driver and
// start/continue handshake, with an APB slave and an interrupt output.
// Assumes all inputs except the pin are synchronous to pclk.
`timescale 1ns/1ps

`include "pcr_params.svh"

module pcr_top
   import pcr_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        soft_reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_wr_pme_enable,
   input  wire logic        cfg_wr_pme_status,
   output logic             cfg_pme_enable,
   output logic             cfg_pme_status,
   input  wire logic        eeprom_load,
   input  wire logic        eeprom_pme_enable,
   input  wire logic        wake_event,
   input  wire logic        xfer_pending,
   input  wire logic        bus_needed,
   input  wire logic        clock_run_line_n_in,
   output logic             clock_run_line_n_out,
   output logic             clock_run_line_n_oe,
   output logic             rx_clk_use_crystal,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////
   // Line synchroniser and receive clock select

   logic line_high;

   pcr_sync2 #(
      .RESET_VAL (1'b1)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (clock_run_line_n_in),
      .sync_out (line_high)
   );

   logic clkreq_sel_r;

   pcr_rx_clk_sel u_rx_sel (
      .pclk           (pclk),
      .presetn        (presetn),
      .mode_clock_run (clkreq_sel_r),
      .line_high      (line_high),
      .use_crystal    (rx_clk_use_crystal)
   );

   ////////////////////////////////////////////////////////////////////////
   // APB decode

   logic wr_acc;
   logic rd_setup;
   logic hit_ctrl;
   logic hit_ists;
   logic hit_imask;
   logic hit_any;

   assign wr_acc    = psel & penable & pwrite;
   assign rd_setup  = psel & ~penable & ~pwrite;
   assign hit_ctrl  = (paddr == `PCR_OFF_CTRL_STATUS);
   assign hit_ists  = (paddr == `PCR_OFF_IRQ_STATUS);
   assign hit_imask = (paddr == `PCR_OFF_IRQ_MASK);
   assign hit_any   = hit_ctrl | hit_ists | hit_imask;
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~hit_any;

   ////////////////////////////////////////////////////////////////////////
   // Handshake state machine

   pcr_state_type state_r;
   pcr_state_type state_nxt;
   pcr_count_type edge_cnt_r;
   pcr_count_type edge_cnt_nxt;
   pcr_count_type idle_cnt_r;
   pcr_count_type idle_cnt_nxt;
   logic          drive_r;
   logic          drive_nxt;
   logic          pme_enable_r;
   logic          want_start;
   logic          want_cont;
   logic          may_assert;
   logic          ev_start;
   logic          ev_cont;

   // Interrupt requests of the host play no part in the decision
   assign want_start = bus_needed;
   assign want_cont  = xfer_pending & ~bus_needed;
   assign may_assert = clkreq_sel_r & pme_enable_r
                       & (idle_cnt_r == `PCR_DEASSERT_EDGES);
   assign ev_start   = (state_r == PCR_IDLE) & may_assert & want_start;
   assign ev_cont    = (state_r == PCR_IDLE) & may_assert & want_cont;

   always_comb begin
      state_nxt    = state_r;
      edge_cnt_nxt = edge_cnt_r;
      drive_nxt    = 1'b0;
      idle_cnt_nxt = idle_cnt_r;
      // Count consecutive deasserted samples, saturating
      if (!line_high) begin
         idle_cnt_nxt = 2'h0;
      end else if (idle_cnt_r != `PCR_DEASSERT_EDGES) begin
         idle_cnt_nxt = idle_cnt_r + 2'h1;
      end
      case (state_r)
         PCR_IDLE: begin
            edge_cnt_nxt = 2'h0;
            if (ev_start | ev_cont) begin
               state_nxt = PCR_DRIVE;
               drive_nxt = 1'b1;
            end
         end
         PCR_DRIVE: begin
            edge_cnt_nxt = edge_cnt_r + 2'h1;
            if (edge_cnt_r + 2'h1 >= `PCR_ASSERT_EDGES) begin
               state_nxt = PCR_WAIT_LOW;
            end else begin
               drive_nxt = 1'b1;
            end
         end
         PCR_WAIT_LOW: begin
            // Central resource keeps the line low after release
            if (!line_high) begin
               state_nxt = PCR_IDLE;
            end
         end
         default: begin
            state_nxt = PCR_IDLE;
         end
      endcase
      if (soft_reset | ~clkreq_sel_r | ~pme_enable_r) begin
         state_nxt = PCR_IDLE;
         drive_nxt = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r    <= PCR_IDLE;
         edge_cnt_r <= 2'h0;
         idle_cnt_r <= 2'h0;
         drive_r    <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         edge_cnt_r <= edge_cnt_nxt;
         idle_cnt_r <= idle_cnt_nxt;
         drive_r    <= drive_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control/status register (hard reset only, soft reset keeps it)

   logic pme_status_r;
   logic pme_status_nxt;
   logic pme_enable_nxt;
   logic clkreq_sel_nxt;
   logic pme_set;

   localparam logic [31:0] CTRL_RST_VAL = `PCR_CTRL_STATUS_RST;

   assign pme_set = wake_event | ev_start | ev_cont;

   always_comb begin
      pme_status_nxt = pme_status_r;
      pme_enable_nxt = pme_enable_r;
      clkreq_sel_nxt = clkreq_sel_r;
      if (eeprom_load) begin
         pme_enable_nxt = eeprom_pme_enable;
      end
      // Config-space and APB paths act on the same flops
      if (cfg_wr) begin
         pme_enable_nxt = cfg_wr_pme_enable;
         if (cfg_wr_pme_status) begin
            pme_status_nxt = 1'b0;
         end
      end
      if (wr_acc & hit_ctrl) begin
         if (pstrb[1]) begin
            pme_enable_nxt = pwdata[`PCR_BIT_PME_ENABLE];
            if (pwdata[`PCR_BIT_PME_STATUS]) begin
               pme_status_nxt = 1'b0;
            end
         end
         if (pstrb[0]) begin
            clkreq_sel_nxt = pwdata[`PCR_BIT_CLKREQ_SEL];
         end
      end
      // A new event beats a clear in the same cycle
      if (pme_set) begin
         pme_status_nxt = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pme_status_r <= CTRL_RST_VAL[`PCR_BIT_PME_STATUS];
         pme_enable_r <= CTRL_RST_VAL[`PCR_BIT_PME_ENABLE];
         clkreq_sel_r <= CTRL_RST_VAL[`PCR_BIT_CLKREQ_SEL];
      end else begin
         pme_status_r <= pme_status_nxt;
         pme_enable_r <= pme_enable_nxt;
         clkreq_sel_r <= clkreq_sel_nxt;
      end
   end

   assign cfg_pme_enable = pme_enable_r;
   assign cfg_pme_status = pme_status_r;

   ////////////////////////////////////////////////////////////////////////
   // Shared pin: low-only drive, gated by the enable bit

   assign clock_run_line_n_out = 1'b0;
   assign clock_run_line_n_oe  = pme_enable_r & (clkreq_sel_r ? drive_r : pme_status_r);

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask

   logic [`PCR_IRQ_W-1:0] ists_r;
   logic [`PCR_IRQ_W-1:0] ists_nxt;
   logic [`PCR_IRQ_W-1:0] imask_r;
   logic [`PCR_IRQ_W-1:0] imask_nxt;
   logic [`PCR_IRQ_W-1:0] ev_vec;

   assign ev_vec = {pme_set, ev_cont, ev_start};

   always_comb begin
      ists_nxt  = ists_r;
      imask_nxt = imask_r;
      if (wr_acc & hit_ists & pstrb[0]) begin
         ists_nxt = ists_r & ~pwdata[`PCR_IRQ_W-1:0];
      end
      if (wr_acc & hit_imask & pstrb[0]) begin
         imask_nxt = pwdata[`PCR_IRQ_W-1:0];
      end
      ists_nxt = ists_nxt | ev_vec;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ists_r  <= `PCR_IRQ_RST;
         imask_r <= `PCR_IRQ_RST;
      end else begin
         ists_r  <= ists_nxt;
         imask_r <= imask_nxt;
      end
   end

   assign irq = |(ists_r & imask_r);

   ////////////////////////////////////////////////////////////////////////
   // Read data, captured in the setup cycle

   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;

   always_comb begin
      prdata_nxt = prdata_r;
      if (rd_setup) begin
         prdata_nxt = 32'h0000_0000;
         if (hit_ctrl) begin
            prdata_nxt[`PCR_BIT_PME_STATUS] = pme_status_r;
            prdata_nxt[`PCR_BIT_PME_ENABLE] = pme_enable_r;
            prdata_nxt[`PCR_BIT_CLKREQ_SEL] = clkreq_sel_r;
         end else if (hit_ists) begin
            prdata_nxt[`PCR_IRQ_W-1:0] = ists_r;
         end else if (hit_imask) begin
            prdata_nxt[`PCR_IRQ_W-1:0] = imask_r;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   assign prdata = prdata_r;

endmodule : pcr_top

// >>> pcr_top_assertions.sv
// Concurrent checks on the clock-run control block ports.
// Assumes the checker is bound into pcr_top; all signals except clock_run_line_n_in are in the pclk domain.
`timescale 1ns/1ps
`include "pcr_params.svh"

module pcr_top_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        cfg_wr,
   input wire logic        cfg_wr_pme_enable,
   input wire logic        cfg_pme_enable,
   input wire logic        cfg_pme_status,
   input wire logic        eeprom_load,
   input wire logic        eeprom_pme_enable,
   input wire logic        wake_event,
   input wire logic        clock_run_line_n_in,
   input wire logic        clock_run_line_n_out,
   input wire logic        clock_run_line_n_oe,
   input wire logic        rx_clk_use_crystal
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       wr_ctrl;
   logic       sel_r, sel_nxt;
   logic [2:0] hi_r, hi_nxt, lo_r, lo_nxt;
   ////////////////////////////////////////////////////////////////////////
   // Mirror of the select bit and pin run lengths
   assign wr_ctrl = psel && penable && pwrite && (paddr == `PCR_OFF_CTRL_STATUS);
   always_comb begin
      sel_nxt = (wr_ctrl && pstrb[0]) ? pwdata[`PCR_BIT_CLKREQ_SEL] : sel_r;
      hi_nxt  = !clock_run_line_n_in ? 3'h0 : (hi_r == 3'h7) ? hi_r : hi_r + 3'h1;
      lo_nxt  = clock_run_line_n_in ? 3'h0 : (lo_r == 3'h7) ? lo_r : lo_r + 3'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_r <= 1'b0;
         hi_r  <= 3'h0;
         lo_r  <= 3'h0;
      end else begin
         sel_r <= sel_nxt;
         hi_r  <= hi_nxt;
         lo_r  <= lo_nxt;
      end
   end
   sequence s_hold_two;
      clock_run_line_n_oe [*2] ##1 !clock_run_line_n_oe;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   AST_OUT_LOW: assert property (clock_run_line_n_out == 1'b0)
      else $error("pin output not low");
   AST_HOLD_TWO: assert property (sel_r && $rose(clock_run_line_n_oe) |-> s_hold_two)
      else $error("request not held two cycles");
   AST_IDLE_FIRST: assert property (sel_r && $rose(clock_run_line_n_oe) |-> hi_r >= 3'h2)
      else $error("request without idle line");
   AST_NO_REQ: assert property (!cfg_pme_enable && !$past(cfg_pme_enable) |-> !clock_run_line_n_oe)
      else $error("pin driven while disabled");
   AST_W0_KEEP: assert property (wr_ctrl && pstrb[1] && !pwdata[15] && cfg_pme_status |=> cfg_pme_status)
      else $error("status lost on zero write");
   AST_W1_CLEAR: assert property (wr_ctrl && pstrb[1] && pwdata[15] && !sel_r && !wake_event
                                  |=> !cfg_pme_status)
      else $error("status not cleared");
   AST_APB_EN: assert property (wr_ctrl && pstrb[1] && !cfg_wr && !eeprom_load
                                |=> cfg_pme_enable == $past(pwdata[8]))
      else $error("enable write lost");
   AST_CFG_EN: assert property (cfg_wr && !wr_ctrl && !eeprom_load
                                |=> cfg_pme_enable == $past(cfg_wr_pme_enable))
      else $error("config enable write lost");
   AST_EEP_EN: assert property (eeprom_load && !cfg_wr && !wr_ctrl
                                |=> cfg_pme_enable == $past(eeprom_pme_enable))
      else $error("autoload enable lost");
   AST_RX_HIGH: assert property (sel_r && $past(sel_r, 2) && hi_r >= 3'h4 |-> rx_clk_use_crystal)
      else $error("rx clock not on crystal");
   AST_RX_LOW: assert property ((!sel_r && !$past(sel_r)) || lo_r >= 3'h4 |-> !rx_clk_use_crystal)
      else $error("rx clock not on pci clock");
endmodule : pcr_top_assertions

bind pcr_top pcr_top_assertions pcr_top_assertions_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .cfg_wr(cfg_wr),
   .cfg_wr_pme_enable(cfg_wr_pme_enable), .cfg_pme_enable(cfg_pme_enable),
   .cfg_pme_status(cfg_pme_status), .eeprom_load(eeprom_load),
   .eeprom_pme_enable(eeprom_pme_enable), .wake_event(wake_event),
   .clock_run_line_n_in(clock_run_line_n_in), .clock_run_line_n_out(clock_run_line_n_out),
   .clock_run_line_n_oe(clock_run_line_n_oe), .rx_clk_use_crystal(rx_clk_use_crystal));

// >>> pcr_clk_resource.sv
// Model of the central clock resource on the shared clock-run line.
// Assumes the line has a pull-up; cr_oe high pulls it low.
`timescale 1ns/1ps

module pcr_clk_resource (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic dev_oe,
   input  wire logic want_stop,
   output logic      cr_oe
);
   logic       seen_r, seen_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   always_comb begin
      seen_nxt = seen_r;
      cnt_nxt  = cnt_r;
      if (dev_oe && !seen_r) begin
         seen_nxt = 1'b1;
         cnt_nxt  = 3'h0;
      end else if (seen_r) begin
         if (cnt_r == 3'h5) seen_nxt = 1'b0;
         else cnt_nxt = cnt_r + 3'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_r <= 1'b0;
         cnt_r  <= 3'h0;
      end else begin
         seen_r <= seen_nxt;
         cnt_r  <= cnt_nxt;
      end
   end
   // Low after device release, for six edges since its assertion
   assign cr_oe = !want_stop || (seen_r && !dev_oe);
endmodule : pcr_clk_resource

// >>> testbench.sv
// Self-checking bench for pcr_top over APB with the clock resource model.
// Assumes the checker is bound in; pin resolved with a pull-up.
`timescale 1ns/1ps

module testbench;
   logic        pclk = 0, presetn = 0, soft_reset = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [3:0]  pstrb = 4'hF;
   logic        pready, pslverr, e, cfg_wr = 0, cfg_en = 0, cfg_st = 0, cfg_pme_enable, cfg_pme_status;
   logic        eep_ld = 0, eep_en = 0, wake = 0, xfer = 0, busn = 0, line_n, l_out, l_oe, rx, irq;
   logic        cr_oe, want_stop = 1;
   int          fail_count = 0, num_checks = 0, oe_cnt = 0;
   assign line_n = (l_oe ? l_out : 1'b1) && !cr_oe;
   pcr_top pcr_top_i (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_wr(cfg_wr),
      .cfg_wr_pme_enable(cfg_en), .cfg_wr_pme_status(cfg_st), .cfg_pme_enable(cfg_pme_enable),
      .cfg_pme_status(cfg_pme_status), .eeprom_load(eep_ld), .eeprom_pme_enable(eep_en),
      .wake_event(wake), .xfer_pending(xfer), .bus_needed(busn), .clock_run_line_n_in(line_n),
      .clock_run_line_n_out(l_out), .clock_run_line_n_oe(l_oe), .rx_clk_use_crystal(rx), .irq(irq));
   pcr_clk_resource pcr_clk_resource_i (.pclk(pclk), .presetn(presetn), .dev_oe(l_oe),
      .want_stop(want_stop), .cr_oe(cr_oe));
   initial begin
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) if (l_oe === 1'b1) oe_cnt++;
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(0, a, 32'h0);
      chk(q, exp);
   endtask : rd
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      #20000;
      fail_count++;
      finish_test;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      rd(12'h03C, 32'h0);
      apb(1, 12'h03C, 32'hFFFF_7FFF);
      rd(12'h03C, 32'h0000_0101);
      apb(1, 12'h03C, 32'h100);
      @(posedge pclk) wake <= 1;
      @(posedge pclk) wake <= 0;
      rd(12'h03C, 32'h8100);
      chk(32'(cfg_pme_status), 1);
      chk(32'(l_oe), 1);
      apb(1, 12'h03C, 32'h100);
      rd(12'h03C, 32'h8100);
      apb(1, 12'h03C, 32'h8100);
      rd(12'h03C, 32'h100);
      @(posedge pclk) wake <= 1;
      @(posedge pclk) begin wake <= 0; cfg_wr <= 1; cfg_st <= 1; end
      @(posedge pclk) cfg_wr <= 0;
      rd(12'h03C, 32'h0);
      @(posedge pclk) begin eep_ld <= 1; eep_en <= 1; end
      @(posedge pclk) eep_ld <= 0;
      rd(12'h03C, 32'h100);
      @(posedge pclk) soft_reset <= 1;
      @(posedge pclk) soft_reset <= 0;
      rd(12'h03C, 32'h100);
      rd(12'h040, 32'h0);
      chk(32'(e), 1);
      apb(1, 12'h03C, 32'h101);
      for (int k = 0; k < 2; k++) begin
         oe_cnt = 0;
         @(posedge pclk) if (k == 0) busn <= 1; else xfer <= 1;
         repeat (4) @(posedge pclk);
         busn <= 0;
         xfer <= 0;
         repeat (16) @(posedge pclk);
         chk(oe_cnt, 2);
         rd(12'h050, (k == 0) ? 32'h5 : 32'h6);
         chk(32'(q[k]), 1);
         apb(1, 12'h054, 32'h1 << k);
         @(posedge pclk) chk(32'(irq), 1);
         chk(oe_cnt, 2);
         apb(1, 12'h050, 32'h7);
         apb(1, 12'h054, 32'h0);
         @(posedge pclk) chk(32'(irq), 0);
      end
      apb(1, 12'h03C, 32'h8001);
      oe_cnt = 0;
      @(posedge pclk) busn <= 1;
      repeat (10) @(posedge pclk);
      busn <= 0;
      chk(oe_cnt, 0);
      chk(32'(rx), 1);
      @(posedge pclk) want_stop <= 0;
      repeat (8) @(posedge pclk);
      chk(32'(rx), 0);
      want_stop <= 1;
      apb(1, 12'h03C, 32'h0);
      repeat (8) @(posedge pclk);
      chk(32'(rx), 0);
      finish_test;
   end
endmodule : testbench
